// File: include/cfg_host_pkg.sv
// Constants and types for the configuration access host controller
package cfg_host_pkg;

   // ----------------------------------------------------------------
   // Bridge I/O ports
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_PORT      = 16'h0CF8;
   localparam logic [15:0] DATA_PORT      = 16'h0CFC;
   localparam logic [3:0]  BE_FULL        = 4'hF;

   // ----------------------------------------------------------------
   // Address port fields
   // ----------------------------------------------------------------
   localparam int          SEL_EN_BIT     = 31;
   localparam int          SEL_RESV_HI    = 30;
   localparam int          SEL_RESV_LO    = 24;
   localparam int          SEL_BUS_LO     = 16;
   localparam int          SEL_DEV_LO     = 11;
   localparam int          SEL_FUNC_LO    = 8;
   localparam int          SEL_INDEX_LO   = 2;
   localparam int          SEL_TYPE_LO    = 0;
   localparam logic [31:0] SEL_WMASK      = 32'h80FF_FFFF;
   localparam logic [31:0] SEL_RST        = 32'h0000_0000;
   localparam logic [1:0]  TYPE_LOCAL     = 2'h0;
   localparam logic [1:0]  TYPE_FORWARD   = 2'h1;

   // ----------------------------------------------------------------
   // Own register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_SEL        = 8'h00;
   localparam logic [7:0]  REG_WDATA      = 8'h04;
   localparam logic [7:0]  REG_CTRL       = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0C;
   localparam logic [7:0]  REG_RDATA      = 8'h10;
   localparam logic [31:0] WORD_RST       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Control and status fields
   // ----------------------------------------------------------------
   localparam int          CTRL_OP_LO     = 0;
   localparam int          CTRL_BE_LO     = 4;
   localparam int          CTRL_START_BIT = 8;
   localparam logic [1:0]  OP_RST         = 2'h0;
   localparam int          OP_READ_BIT    = 0;
   localparam int          OP_DATA_BIT    = 1;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_DONE_BIT  = 1;

   // ----------------------------------------------------------------
   // Synchroniser width: link clock, acknowledge, read data
   // ----------------------------------------------------------------
   localparam int          SYNC_W         = 34;
   localparam int          SYNC_LCLK      = 33;
   localparam int          SYNC_ACK       = 32;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_ISSUE   = 2'h1,
      ST_WAIT    = 2'h3,
      ST_RELEASE = 2'h2
   } state_e;

endpackage

// File: rtl/sync_bits.sv
// Two-stage synchroniser for a group of independent bits
`timescale 1ns/1ps
module sync_bits #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // ----------------------------------------------------------------
   // One pair of flip-flops per bit
   // ----------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta[i] <= 1'b0;
            q[i]    <= 1'b0;
         end else if (ce) begin
            meta[i] <= d[i];
            q[i]    <= meta[i];
         end
      end
   end

endmodule

// File: rtl/cfg_access_host.sv
// Host controller driving a configuration address/data port bridge
`timescale 1ns/1ps

module cfg_access_host
   import cfg_host_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        link_clk,
   input  wire logic        io_ack,
   input  wire logic [31:0] io_rdata,
   output logic             io_req,
   output logic             io_write,
   output logic      [15:0] io_addr,
   output logic      [3:0]  io_be,
   output logic      [31:0] io_wdata
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync_q;
   logic              lclk_s;
   logic              lclk_d;
   logic              ack_s;
   logic [31:0]       rdata_s;
   logic              link_fall;
   logic              addr_take;
   logic              wr_pend;
   logic [7:0]        wr_off;
   logic              wr_sel;
   logic              wr_wdata;
   logic              wr_ctrl;
   logic [7:0]        rd_off;
   logic [31:0]       read_val;
   logic [31:0]       sel_reg;
   logic [31:0]       wdata_reg;
   logic [1:0]        op_reg;
   logic [3:0]        be_reg;
   logic [31:0]       rdata_reg;
   logic              done;
   logic              busy;
   logic              start;
   logic              be_ok;
   logic [3:0]        be_use;
   logic [31:0]       ctrl_val;
   logic [31:0]       status_val;
   state_e            state;
   state_e            next_state;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ----------------------------------------------------------------
   // Pin synchronisers and link clock falling edge
   // ----------------------------------------------------------------
   sync_bits #(
      .W     (SYNC_W)
   ) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .ce    (ce),
      .d     ({link_clk, io_ack, io_rdata}),
      .q     (sync_q)
   );

   assign lclk_s    = sync_q[SYNC_LCLK];
   assign ack_s     = sync_q[SYNC_ACK];
   assign rdata_s   = sync_q[31:0];
   assign link_fall = lclk_d & ~lclk_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lclk_d <= 1'b0;
      end else if (ce) begin
         lclk_d <= lclk_s;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave decode
   // ----------------------------------------------------------------
   assign addr_take = hsel & htrans[1] & hready;
   assign rd_off    = haddr[7:0];
   assign wr_sel    = wr_pend & (wr_off == REG_SEL);
   assign wr_wdata  = wr_pend & (wr_off == REG_WDATA);
   assign wr_ctrl   = wr_pend & (wr_off == REG_CTRL);
   assign busy      = (state != ST_IDLE);
   assign start     = wr_ctrl & hwdata[CTRL_START_BIT] & ~busy;

   assign ctrl_val   = {24'h00_0000, be_reg, 2'h0, op_reg};
   assign status_val = {30'h0000_0000, done, busy};
   assign read_val   = (rd_off == REG_SEL)    ? sel_reg    :
                       (rd_off == REG_WDATA)  ? wdata_reg  :
                       (rd_off == REG_CTRL)   ? ctrl_val   :
                       (rd_off == REG_STATUS) ? status_val :
                       (rd_off == REG_RDATA)  ? rdata_reg  :
                       WORD_RST;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_off  <= 8'h00;
      end else if (ce) begin
         wr_pend <= addr_take & hwrite;
         wr_off  <= rd_off;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= WORD_RST;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_take & ~hwrite) begin
            hrdata <= read_val;
         end
      end
   end

   // ----------------------------------------------------------------
   // Own registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_reg   <= SEL_RST;
         wdata_reg <= WORD_RST;
      end else if (ce) begin
         if (wr_sel) begin
            sel_reg <= hwdata & SEL_WMASK;
         end
         if (wr_wdata) begin
            wdata_reg <= hwdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_reg <= OP_RST;
         be_reg <= BE_FULL;
      end else if (ce && start) begin
         op_reg <= hwdata[CTRL_OP_LO +: 2];
         be_reg <= hwdata[CTRL_BE_LO +: 4];
      end
   end

   // ----------------------------------------------------------------
   // Byte lane check for the data port
   // ----------------------------------------------------------------
   assign be_ok  = (hwdata[CTRL_BE_LO +: 4] == 4'h1) |
                   (hwdata[CTRL_BE_LO +: 4] == 4'h2) |
                   (hwdata[CTRL_BE_LO +: 4] == 4'h4) |
                   (hwdata[CTRL_BE_LO +: 4] == 4'h8) |
                   (hwdata[CTRL_BE_LO +: 4] == 4'h3) |
                   (hwdata[CTRL_BE_LO +: 4] == 4'hC) |
                   (hwdata[CTRL_BE_LO +: 4] == BE_FULL);
   assign be_use = be_ok ? hwdata[CTRL_BE_LO +: 4] : BE_FULL;

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start) begin
               next_state = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (link_fall) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (ack_s & link_fall) begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (~ack_s) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Bridge port outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_write <= 1'b0;
         io_addr  <= ADDR_PORT;
         io_be    <= BE_FULL;
         io_wdata <= WORD_RST;
      end else if (ce && start) begin
         io_write <= ~hwdata[CTRL_OP_LO + OP_READ_BIT];
         if (hwdata[CTRL_OP_LO + OP_DATA_BIT]) begin
            io_addr  <= DATA_PORT;
            io_be    <= be_use;
            io_wdata <= wdata_reg;
         end else begin
            io_addr  <= ADDR_PORT;
            io_be    <= BE_FULL;
            io_wdata <= sel_reg;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_req <= 1'b0;
      end else if (ce) begin
         if (state == ST_ISSUE && link_fall) begin
            io_req <= 1'b1;
         end else if (state == ST_WAIT && ack_s && link_fall) begin
            io_req <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= WORD_RST;
         done      <= 1'b0;
      end else if (ce) begin
         if (state == ST_WAIT && ack_s && link_fall && !io_write) begin
            rdata_reg <= rdata_s;
         end
         if (start) begin
            done <= 1'b0;
         end else if (state == ST_RELEASE && !ack_s) begin
            done <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_ack_seen;
      ce && state == ST_WAIT && ack_s && link_fall;
   endsequence

   sequence s_req_dropped;
      !io_req ##0 state == ST_RELEASE;
   endsequence

   a_addr_full_be: assert property (
      io_req && io_addr == ADDR_PORT |-> io_be == BE_FULL)
      else $error("address port access not a full word");

   a_resv_zero: assert property (
      sel_reg[SEL_RESV_HI:SEL_RESV_LO] == 7'h00)
      else $error("reserved selector bits not zero");

   a_data_be_legal: assert property (
      io_req && io_addr == DATA_PORT |->
         io_be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
      else $error("illegal data port byte lanes");

   a_req_stable: assert property (
      io_req && $past(io_req) |->
         $stable(io_addr) && $stable(io_wdata) && $stable(io_be))
      else $error("request fields changed while request high");

   a_req_on_fall: assert property (
      $rose(io_req) |-> $past(link_fall) && $past(state) == ST_ISSUE)
      else $error("request raised away from a link clock fall");

   a_sel_image: assert property (
      ce && start && !hwdata[CTRL_OP_LO + OP_DATA_BIT] |=>
         io_wdata == $past(sel_reg) && io_addr == ADDR_PORT)
      else $error("address port write does not carry selector");

   a_ack_release: assert property (
      s_ack_seen |=> s_req_dropped)
      else $error("request not dropped after acknowledge");

   a_rdata_capture: assert property (
      s_ack_seen ##0 !io_write |=> rdata_reg == $past(rdata_s))
      else $error("read data not captured on acknowledge");

   a_done_set: assert property (
      ce && state == ST_RELEASE && !ack_s |=> done && state == ST_IDLE)
      else $error("completion not flagged");

   a_start_issue: assert property (
      ce && start |=> state == ST_ISSUE && !io_req)
      else $error("start did not enter issue");

   a_busy_hold: assert property (
      busy && wr_ctrl |=>
         $stable(io_addr) && $stable(io_wdata) && $stable(io_write))
      else $error("start accepted while busy");

   a_req_wait: assert property (
      io_req == (state == ST_WAIT))
      else $error("request level differs from wait state");

endmodule

// File: tb/cfg_bridge_model.sv
// Behavioural configuration bridge seen by the host controller
`timescale 1ns/1ps
module cfg_bridge_model
   import cfg_host_pkg::*;
#(
   parameter logic [31:0] ID_WORD = 32'h00015A5A // Arbitrary identity value
) (
   input  wire logic        link_clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        io_req,
   input  wire logic        io_write,
   input  wire logic [15:0] io_addr,
   input  wire logic [3:0]  io_be,
   input  wire logic [31:0] io_wdata,
   output logic             io_ack,
   output logic      [31:0] io_rdata,
   output logic      [3:0]  last_be,
   output logic      [7:0]  acc_count
);
   // ------------------------------------------------------------
   // Port storage and lookup
   // ------------------------------------------------------------
   logic [31:0] sel;
   logic [31:0] space [logic [23:0]];
   logic [1:0]  dly;

   function automatic logic [31:0] rd_val();
      if (io_addr == ADDR_PORT) return sel;
      if (!sel[SEL_EN_BIT]) return 32'hFFFFFFFF;
      if (sel[7:2] == 6'h0) return ID_WORD;
      if (space.exists(sel[23:0])) return space[sel[23:0]];
      return 32'h0;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (io_be[b]) m[8*b+:8] = io_wdata[8*b+:8];
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // Four-phase answer on the link clock
   // ------------------------------------------------------------
   always @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_ack <= 1'b0;
         io_rdata <= 32'h0;
         sel <= 32'h0;
         dly <= 2'h0;
         last_be <= 4'h0;
         acc_count <= 8'h0;
      end else if (io_req && !io_ack && slow && dly != 2'h3) begin
         dly <= dly + 2'h1;
      end else if (io_req && !io_ack) begin
         dly <= 2'h0;
         io_ack <= 1'b1;
         io_rdata <= rd_val();
         last_be <= io_be;
         acc_count <= acc_count + 8'h1;
         if (io_write && io_addr == ADDR_PORT && io_be == BE_FULL) begin
            sel <= io_wdata & SEL_WMASK;
         end else if (io_write && io_addr == DATA_PORT &&
                      sel[SEL_EN_BIT] && sel[7:2] != 6'h0) begin
            space[sel[23:0]] = merge(rd_val());
         end
      end else if (!io_req && io_ack) begin
         io_ack <= 1'b0;
         io_rdata <= ~io_rdata;
      end
   end
endmodule

// File: tb/test_cfg_access_host.sv
// Self-checking bench for the configuration access host controller
`timescale 1ns/1ps
module test_cfg_access_host
   import cfg_host_pkg::*;
   ;
   localparam logic [31:0] ID_WORD = 32'h00015A5A; // Arbitrary identity value
   typedef struct packed {
      logic [1:0]  op;
      logic [3:0]  be;
      logic [31:0] sel;
      logic [31:0] wd;
      logic [31:0] exp;
   } row_s;
   logic        hclk, hresetn, ce, hsel, hwrite, link_clk, slow;
   logic        hready, hreadyout, hresp, io_ack, io_req, io_write;
   logic [31:0] haddr, hwdata, hrdata, io_rdata, io_wdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] io_addr;
   logic [3:0]  io_be, last_be;
   logic [7:0]  acc_count, c0;
   int          err_total, check_count;
   row_s        rows [17] = '{
      '{2'h0, 4'hF, 32'h80000804, 32'h0, 32'h0},
      '{2'h1, 4'hF, 32'h80000804, 32'h0, 32'h80000804},
      '{2'h2, 4'hF, 32'h80000804, 32'h11223344, 32'h0},
      '{2'h2, 4'h1, 32'h80000804, 32'hAABBCCDD, 32'h0},
      '{2'h3, 4'hF, 32'h80000804, 32'h0, 32'h112233DD},
      '{2'h0, 4'hF, 32'h80000805, 32'h0, 32'h0},
      '{2'h3, 4'hF, 32'h80000805, 32'h0, 32'h0},
      '{2'h0, 4'hF, 32'h00000804, 32'h0, 32'h0},
      '{2'h2, 4'hF, 32'h00000804, 32'h0, 32'h0},
      '{2'h3, 4'hF, 32'h00000804, 32'h0, 32'hFFFFFFFF},
      '{2'h0, 4'hF, 32'h80000800, 32'h0, 32'h0},
      '{2'h3, 4'hF, 32'h80000800, 32'h0, ID_WORD},
      '{2'h0, 4'hF, 32'h80000804, 32'h0, 32'h0},
      '{2'h3, 4'hF, 32'h80000804, 32'h0, 32'h112233DD},
      '{2'h2, 4'hC, 32'h80000804, 32'hA1B2C3D4, 32'h0},
      '{2'h2, 4'h2, 32'h80000804, 32'h0000EE00, 32'h0},
      '{2'h3, 4'hF, 32'h80000804, 32'h0, 32'hA1B2EEDD}
   };

   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;

   cfg_access_host i_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
      .io_ack(io_ack), .io_rdata(io_rdata), .io_req(io_req),
      .io_write(io_write), .io_addr(io_addr), .io_be(io_be),
      .io_wdata(io_wdata)
   );
   cfg_bridge_model #(.ID_WORD(ID_WORD)) i_bridge (
      .link_clk(link_clk), .rst_n(hresetn), .slow(slow),
      .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
      .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack),
      .io_rdata(io_rdata), .last_be(last_be), .acc_count(acc_count)
   );

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      q = hrdata;
      if (n >= 100) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 32'h0, q);
   endtask

   task automatic wait_done();
      logic [31:0] s;
      int n;
      rd(REG_STATUS, s);
      n = 0;
      do begin
         rd(REG_STATUS, s);
         n++;
      end while (s[STAT_DONE_BIT] !== 1'b1 && n < 400);
      if (n >= 400) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic run_op(input logic [1:0] op, input logic [3:0] be);
      wr(REG_CTRL, {23'h0, 1'b1, be, 2'h0, op});
      wait_done();
   endtask

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      #37;
      forever #100 link_clk = ~link_clk;
   end

   initial begin
      repeat (60000) @(posedge hclk);
      err_total++;
      conclude();
   end

   initial begin
      hclk = 1'b0;
      link_clk = 1'b0;
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      slow = 1'b0;
      err_total = 0;
      check_count = 0;
      repeat (4) @(posedge hclk);
      check({hreadyout, hresp, io_req, io_be}, {3'h4, BE_FULL});
      check({io_addr, 16'h0}, {ADDR_PORT, 16'h0});
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < $size(rows); i++) begin
         slow <= i[1];
         wr(REG_SEL, rows[i].sel);
         wr(REG_WDATA, rows[i].wd);
         run_op(rows[i].op, rows[i].be);
         check({31'h0, io_write},
               {31'h0, ~rows[i].op[OP_READ_BIT]});
         check({16'h0, io_addr}, rows[i].op[OP_DATA_BIT] ?
               {16'h0, DATA_PORT} : {16'h0, ADDR_PORT});
         if (rows[i].op == 2'h0) begin
            check({28'h0, last_be}, {28'h0, BE_FULL});
         end
         if (rows[i].op[OP_READ_BIT]) begin
            rd(REG_RDATA, r);
            check(r, rows[i].exp);
         end
      end
      wr(REG_SEL, 32'hFFFFFFFF);
      rd(REG_SEL, r);
      check(r, 32'h80FFFFFF);
      ce <= 1'b0;
      wr(REG_SEL, 32'h00000000);
      ce <= 1'b1;
      rd(REG_SEL, r);
      check(r, 32'h80FFFFFF);
      wr(8'h14, 32'h12345678);
      rd(8'h14, r);
      check(r, 32'h0);
      wr(REG_SEL, 32'h80000808);
      run_op(2'h0, 4'hF);
      wr(REG_WDATA, 32'h0);
      run_op(2'h2, 4'hF);
      wr(REG_WDATA, 32'hFFFFFFFF);
      run_op(2'h2, 4'h5);
      run_op(2'h3, 4'hF);
      rd(REG_RDATA, r);
      check(r, 32'hFFFFFFFF);
      c0 = acc_count;
      wr(REG_CTRL, 32'h00000101);
      wr(REG_CTRL, 32'h00000101);
      wait_done();
      repeat (80) @(posedge hclk);
      check({24'h0, acc_count}, {24'h0, c0 + 8'h1});
      wr(REG_CTRL, 32'h00000101);
      repeat (20) @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      #1;
      check({31'h0, io_req}, 32'h0);
      check(hrdata, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(REG_SEL, r);
      check(r, 32'h0);
      conclude();
   end
endmodule
